// ===== rtl/flash_status_ctl.sv
// Overview of operation
// - status read command makes reads return status
// - reset leaves status at engine ready only
// - abort flag cleared only by clear or reset
// - bit 7 low while busy, high when ready
// - bit 6 high only while erase suspended
// - bit 1 set by locked abort, held until clear or reset
// - erase one region by any address, all ones
// - reads return status after erase command
// - locked erase fails and sets abort flag
// - locked program fails and sets abort flag
// - reads return status during program
// - one suspend code, one resume code for both
// - suspend halts erase within latency, status reads
// - successful erase suspend sets suspended flag
// - suspended region program acknowledged, not executed
// - suspended erase accepts status, id, resume
// - resume waits for program during suspension
// - program suspend and resume do nothing
// - 256-bit id space, factory low eight bytes
// - lockout freezes user id bytes until reset
// - id command maps reads to identity data
`timescale 1ns/1ps
module flash_status_ctl
    import flash_ctl_pkg::*;
#(
    parameter int SECTOR_ERASE_CNT = SECTOR_ERASE_CYCLES,
    parameter int BLOCK_ERASE_CNT  = BLOCK_ERASE_CYCLES
)
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    input  wire logic [31:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        target_locked,
    input  wire logic [7:0]  arr_rdata,
    output logic      [7:0]  rd_data,
    output logic             rd_valid,
    output logic             arr_erase,
    output logic             arr_program,
    output logic             arr_block,
    output logic      [31:0] arr_addr,
    output logic      [7:0]  arr_wdata
);
    import flash_ctl_pkg::*;

    localparam int susp_lat = SUSPEND_LATENCY_CYCLES;

    engine_t     eng_q, eng_d;
    read_mode_t  mode_q, mode_d;
    pend_t       pend_q, pend_d;
    logic        abort_q;
    logic        resume_pend_q;
    logic [31:0] region_q;
    logic [31:0] region_mask_q;
    logic [7:0]  rd_data_q;
    logic        rd_valid_q;
    logic        arr_erase_q;
    logic        arr_program_q;
    logic        arr_block_q;
    logic [31:0] arr_addr_q;
    logic [7:0]  arr_wdata_q;
    timer_if #(.W(TIMER_W)) erase_t ();
    timer_if #(.W(TIMER_W)) prog_t ();
    op_timer #(.W(TIMER_W)) erase_timer (.mclk(mclk), .rst(rst), .t(erase_t.cnt));
    op_timer #(.W(TIMER_W)) prog_timer  (.mclk(mclk), .rst(rst), .t(prog_t.cnt));

    // engine condition
    wire idle      = eng_q == ENG_IDLE;
    wire susp      = eng_q == ENG_SUSPENDED;
    wire busy      = !(idle || susp);
    wire erase_sus = susp || eng_q == ENG_PROG_SUSP;

    wire [7:0] status_byte;
    assign status_byte[READY_BIT]     = !busy;
    assign status_byte[SUSPENDED_BIT] = erase_sus;
    assign status_byte[ABORT_BIT]     = abort_q;
    assign status_byte[5:2]           = 4'h0;
    assign status_byte[0]             = 1'b0;
    // first cycle decode, filtered by what the engine state allows
    wire first      = wr_stb && pend_q == PEND_NONE;
    wire second     = wr_stb && pend_q != PEND_NONE;
    wire c_status   = first && wdata == CMD_READ_STATUS;
    wire c_clear    = first && wdata == CMD_CLEAR_STATUS && !busy;
    wire c_array    = first && wdata == CMD_READ_ARRAY && !busy;
    wire c_id       = first && wdata == CMD_READ_ID && !busy;
    wire c_sector   = first && wdata == CMD_SECTOR_ERASE && idle;
    wire c_block    = first && wdata == CMD_BLOCK_ERASE && idle;
    wire c_prog     = first && (wdata == CMD_PROGRAM || wdata == CMD_PROGRAM_ALT) && !busy;
    // a suspend during a program falls through with no effect
    wire c_suspend  = first && wdata == CMD_SUSPEND && eng_q == ENG_ERASE;
    wire c_resume   = first && wdata == CMD_RESUME && erase_sus;
    wire c_sid_prog = first && wdata == CMD_SID_PROGRAM && idle;
    wire c_sid_lock = first && wdata == CMD_SID_LOCKOUT && idle;
    // second cycle
    wire erase_conf = second && (pend_q == PEND_SECTOR || pend_q == PEND_BLOCK)
                      && wdata == CMD_RESUME;
    wire prog_data  = second && pend_q == PEND_PROGRAM;
    wire [31:0] sel_mask = (pend_q == PEND_BLOCK) ? BLOCK_MASK : SECTOR_MASK;
    wire in_region  = (addr & region_mask_q) == region_q;
    wire erase_go   = erase_conf && !target_locked;
    wire erase_lock = erase_conf && target_locked;
    wire prog_skip  = prog_data && erase_sus && in_region;
    wire prog_lock  = prog_data && !prog_skip && target_locked;
    wire prog_go    = prog_data && !prog_skip && !target_locked;
    wire sid_wr     = second && pend_q == PEND_SID_PROGRAM;
    wire sid_lk     = second && pend_q == PEND_SID_LOCKOUT && wdata == SID_LOCKOUT_KEY;
    wire erase_done = erase_t.done;
    wire prog_done  = prog_t.done;

    // identification read path
    wire [31:0] sid_off = addr - SID_BASE;
    wire        in_sid  = addr >= SID_BASE && addr <= SID_LAST;
    wire [7:0]  sid_byte;
    secid_store sid (
        .mclk    (mclk),
        .rst     (rst),
        .wr_en   (sid_wr && in_sid),
        .wr_idx  (sid_off[4:0]),
        .wdata   (wdata),
        .lock_en (sid_lk),
        .rd_idx  (sid_off[4:0]),
        .rd_data (sid_byte),
        .locked  ()
    );
    wire [7:0] id_byte = (addr == MFR_ID_ADDR) ? MFR_CODE :
                         (addr == DEV_ID_ADDR) ? DEV_CODE :
                         in_sid                ? sid_byte : 8'h00;
    // an engine at work always answers with status, whatever the mode
    wire show_status = busy || mode_q == MODE_STATUS;
    wire [7:0] rd_next = show_status       ? status_byte :
                         mode_q == MODE_ID ? id_byte : arr_rdata;
    // timers
    assign erase_t.start = erase_go;
    assign erase_t.load  = (pend_q == PEND_BLOCK) ? TIMER_W'(BLOCK_ERASE_CNT)
                                                  : TIMER_W'(SECTOR_ERASE_CNT);
    assign erase_t.run   = eng_q == ENG_ERASE;
    assign prog_t.start  = prog_go;
    assign prog_t.load   = TIMER_W'(BYTE_PROGRAM_CYCLES);
    assign prog_t.run    = 1'b1;

    always_comb
    begin
        eng_d = eng_q;
        unique case (eng_q)
            ENG_IDLE:
                if (erase_go)
                    eng_d = ENG_ERASE;
                else if (prog_go)
                    eng_d = ENG_PROGRAM;
            ENG_PROGRAM:
                if (prog_done)
                    eng_d = ENG_IDLE;
            ENG_ERASE:
                if (erase_done)
                    eng_d = ENG_IDLE;
                else if (c_suspend)
                    eng_d = ENG_SUSPENDED;
            ENG_SUSPENDED:
                // an erase that finished as the suspend landed is simply complete
                if (erase_done)
                    eng_d = ENG_IDLE;
                else if (prog_go)
                    eng_d = ENG_PROG_SUSP;
                else if (c_resume)
                    eng_d = ENG_ERASE;
            ENG_PROG_SUSP:
                if (prog_done)
                    eng_d = (resume_pend_q || c_resume) ? ENG_ERASE : ENG_SUSPENDED;
        endcase
    end

    always_comb
    begin
        mode_d = mode_q;
        if (c_status || c_suspend || c_sector || c_block || c_prog)
            mode_d = MODE_STATUS;
        else if (c_array)
            mode_d = MODE_ARRAY;
        else if (c_id)
            mode_d = MODE_ID;
    end

    always_comb
    begin
        pend_d = pend_q;
        if (second)
            pend_d = PEND_NONE;
        else if (c_sector)
            pend_d = PEND_SECTOR;
        else if (c_block)
            pend_d = PEND_BLOCK;
        else if (c_prog)
            pend_d = PEND_PROGRAM;
        else if (c_sid_prog)
            pend_d = PEND_SID_PROGRAM;
        else if (c_sid_lock)
            pend_d = PEND_SID_LOCKOUT;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            eng_q  <= ENG_IDLE;
            mode_q <= MODE_ARRAY;
            pend_q <= PEND_NONE;
        end
        else
        begin
            eng_q  <= eng_d;
            mode_q <= mode_d;
            pend_q <= pend_d;
        end
    end

    // lock-abort flag: a new abort beats a clear in the same cycle
    always_ff @(posedge mclk)
    begin
        if (rst)
            abort_q <= 1'b0;
        else if (erase_lock || prog_lock)
            abort_q <= 1'b1;
        else if (c_clear)
            abort_q <= 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            resume_pend_q <= 1'b0;
        else if (eng_q != ENG_PROG_SUSP)
            resume_pend_q <= 1'b0;
        else if (c_resume)
            resume_pend_q <= 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            region_q      <= 32'h00000000;
            region_mask_q <= 32'h00000000;
        end
        else if (erase_go)
        begin
            region_q      <= addr & sel_mask;
            region_mask_q <= sel_mask;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            arr_erase_q   <= 1'b0;
            arr_program_q <= 1'b0;
            arr_block_q   <= 1'b0;
            arr_addr_q    <= 32'h00000000;
            arr_wdata_q   <= 8'hFF;
            rd_data_q     <= 8'h00;
            rd_valid_q    <= 1'b0;
        end
        else
        begin
            arr_erase_q   <= erase_go;
            arr_program_q <= prog_go;
            if (erase_go)
            begin
                arr_block_q <= pend_q == PEND_BLOCK;
                arr_addr_q  <= addr & sel_mask;
                arr_wdata_q <= 8'hFF;
            end
            else if (prog_go)
            begin
                arr_block_q <= 1'b0;
                arr_addr_q  <= addr;
                arr_wdata_q <= wdata;
            end
            rd_valid_q <= rd_stb;
            if (rd_stb)
                rd_data_q <= rd_next;
        end
    end

    assign rd_data     = rd_data_q;
    assign rd_valid    = rd_valid_q;
    assign arr_erase   = arr_erase_q;
    assign arr_program = arr_program_q;
    assign arr_block   = arr_block_q;
    assign arr_addr    = arr_addr_q;
    assign arr_wdata   = arr_wdata_q;

    reset_state_a:
    assert property (@(posedge mclk)
        rst |=> (eng_q == ENG_IDLE && !abort_q && status_byte == STATUS_RESET))
    else $error("status not at default after reset");
    status_read_a:
    assert property (@(posedge mclk) disable iff (rst)
        (mode_q == MODE_STATUS && rd_stb) |=> (rd_valid_q && rd_data_q == $past(status_byte)))
    else $error("status mode read did not return status");
    busy_read_a:
    assert property (@(posedge mclk) disable iff (rst)
        (eng_q == ENG_PROGRAM && rd_stb) |=> (rd_data_q[READY_BIT] == 1'b0))
    else $error("read during program did not show busy status");
    abort_clear_a:
    assert property (@(posedge mclk) disable iff (rst)
        $fell(abort_q) |-> $past(c_clear || rst))
    else $error("abort flag cleared without clear command");
    locked_erase_a:
    assert property (@(posedge mclk) disable iff (rst)
        erase_lock |=> (abort_q && !arr_erase_q && eng_q == ENG_IDLE))
    else $error("locked erase was not aborted");
    erase_region_a:
    assert property (@(posedge mclk) disable iff (rst)
        erase_go |=> (arr_erase_q && arr_addr_q == ($past(addr) & $past(sel_mask))
                      && arr_wdata_q == 8'hFF))
    else $error("erase start did not address one region");
    suspend_flag_a:
    assert property (@(posedge mclk) disable iff (rst)
        (c_suspend && !erase_done) |-> ##[1:susp_lat] status_byte[SUSPENDED_BIT])
    else $error("erase not suspended within latency");
    region_prog_a:
    assert property (@(posedge mclk) disable iff (rst)
        prog_skip |=> (!arr_program_q && eng_q == ENG_SUSPENDED))
    else $error("program inside suspended region was executed");
    resume_wait_a:
    assert property (@(posedge mclk) disable iff (rst)
        (eng_q == ENG_PROG_SUSP && !prog_done) |=> eng_q != ENG_ERASE)
    else $error("erase resumed before program finished");
endmodule

// ===== rtl/flash_ctl_pkg.sv
package flash_ctl_pkg;

    // clock and timing
    localparam int CLK_MHZ                = 40;
    localparam int BYTE_PROGRAM_TIME_NS   = 10000;
    localparam int SUSPEND_LATENCY_NS     = 10000;
    localparam int SECTOR_ERASE_TIME_US   = 25000;
    localparam int BLOCK_ERASE_TIME_US    = 25000;
    localparam int BYTE_PROGRAM_CYCLES    = (BYTE_PROGRAM_TIME_NS * CLK_MHZ) / 1000;
    localparam int SUSPEND_LATENCY_CYCLES = (SUSPEND_LATENCY_NS * CLK_MHZ) / 1000;
    localparam int SECTOR_ERASE_CYCLES    = SECTOR_ERASE_TIME_US * CLK_MHZ;
    localparam int BLOCK_ERASE_CYCLES     = BLOCK_ERASE_TIME_US * CLK_MHZ;
    localparam int TIMER_W                = 24;

    // command codes
    localparam logic [7:0] CMD_READ_ARRAY    = 8'hFF;
    localparam logic [7:0] CMD_READ_ID       = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;
    localparam logic [7:0] CMD_SECTOR_ERASE  = 8'h30;
    localparam logic [7:0] CMD_BLOCK_ERASE   = 8'h20;
    localparam logic [7:0] CMD_PROGRAM       = 8'h40;
    localparam logic [7:0] CMD_PROGRAM_ALT   = 8'h10;
    localparam logic [7:0] CMD_SUSPEND       = 8'hB0;
    localparam logic [7:0] CMD_RESUME        = 8'hD0;
    localparam logic [7:0] CMD_SID_PROGRAM   = 8'hA5;
    localparam logic [7:0] CMD_SID_LOCKOUT   = 8'h85;
    localparam logic [7:0] SID_LOCKOUT_KEY   = 8'h00;

    // operation_status layout
    localparam logic [7:0] STATUS_RESET      = 8'h80;
    localparam int         READY_BIT         = 7;
    localparam int         SUSPENDED_BIT     = 6;
    localparam int         ABORT_BIT         = 1;

    // identification space
    localparam logic [31:0] MFR_ID_ADDR      = 32'hFFFC0000;
    localparam logic [31:0] DEV_ID_ADDR      = 32'hFFFC0001;
    localparam logic [31:0] SID_BASE         = 32'hFFFC0180;
    localparam logic [31:0] SID_LAST         = 32'hFFFC019F;
    localparam int          SID_BYTES        = 32;
    localparam int          SID_FACTORY      = 8;
    // arbitrary values, not tied to any maker
    localparam logic [7:0]  MFR_CODE         = 8'h3C;
    localparam logic [7:0]  DEV_CODE         = 8'hA1;
    localparam logic [63:0] FACTORY_SID      = 64'h0123456789ABCDEF;

    // erase region sizes
    localparam logic [31:0] SECTOR_MASK      = 32'hFFFFF000;
    localparam logic [31:0] BLOCK_MASK       = 32'hFFFF0000;

    typedef enum logic [1:0] {MODE_ARRAY, MODE_STATUS, MODE_ID} read_mode_t;
    typedef enum logic [2:0] {ENG_IDLE, ENG_PROGRAM, ENG_ERASE, ENG_SUSPENDED,
                              ENG_PROG_SUSP} engine_t;
    typedef enum logic [2:0] {PEND_NONE, PEND_SECTOR, PEND_BLOCK, PEND_PROGRAM,
                              PEND_SID_PROGRAM, PEND_SID_LOCKOUT} pend_t;

endpackage

// ===== rtl/timer_if.sv
`timescale 1ns/1ps
interface timer_if #(parameter int W = 24);
    logic         start;
    logic         run;
    logic [W-1:0] load;
    logic         done;

    modport ctl (output start, output run, output load, input done);
    modport cnt (input start, input run, input load, output done);
endinterface

// ===== rtl/op_timer.sv
`timescale 1ns/1ps
module op_timer #(parameter int W = 24)
(
    input wire logic mclk,
    input wire logic rst,
    timer_if.cnt     t
);
    logic [W-1:0] count_q;
    logic         done_q;
    wire          last = (count_q == W'(1));

    // pausing freezes the remaining count, which is what lets an erase resume
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            count_q <= '0;
            done_q  <= 1'b0;
        end
        else
        begin
            done_q <= t.run && last && !t.start;
            if (t.start)
                count_q <= t.load;
            else if (t.run && count_q != '0)
                count_q <= count_q - W'(1);
        end
    end

    assign t.done = done_q;
endmodule

// ===== rtl/secid_store.sv
`timescale 1ns/1ps
module secid_store
    import flash_ctl_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       wr_en,
    input  wire logic [4:0] wr_idx,
    input  wire logic [7:0] wdata,
    input  wire logic       lock_en,
    input  wire logic [4:0] rd_idx,
    output logic      [7:0] rd_data,
    output logic            locked
);
    logic [7:0] user_q [SID_BYTES-SID_FACTORY];
    logic       locked_q;

    wire  user_wr   = wr_en && !locked_q && wr_idx >= 5'(SID_FACTORY);
    wire  [4:0] wslot = wr_idx - 5'(SID_FACTORY);
    wire  [4:0] rslot = rd_idx - 5'(SID_FACTORY);

    // one-time cells: programming can only pull bits low
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            locked_q <= 1'b0;
            for (int i = 0; i < SID_BYTES - SID_FACTORY; i++)
                user_q[i] <= 8'hFF;
        end
        else
        begin
            if (lock_en)
                locked_q <= 1'b1;
            if (user_wr)
                user_q[wslot] <= user_q[wslot] & wdata;
        end
    end

    assign rd_data = (rd_idx < 5'(SID_FACTORY)) ? FACTORY_SID[rd_idx[2:0]*8 +: 8]
                                                 : user_q[rslot];
    assign locked  = locked_q;

    user_locked_a:
    assert property (@(posedge mclk) disable iff (rst)
        (locked_q && wr_en && wr_idx >= 5'(SID_FACTORY))
            |=> user_q[$past(wslot)] == $past(user_q[wslot]))
    else $error("user id segment changed after lockout");
endmodule

// ===== tb/flash_array_model.sv
`timescale 1ns/1ps
module flash_array_model
    import flash_ctl_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] lock_base,
    input  wire logic        arr_erase,
    input  wire logic        arr_program,
    input  wire logic        arr_block,
    input  wire logic [31:0] arr_addr,
    input  wire logic [7:0]  arr_wdata,
    output logic             target_locked,
    output logic      [7:0]  arr_rdata
);
    // only the low 128 KB is stored, enough for two blocks
    logic [7:0]  mem [131072];
    logic [31:0] emask;

    assign emask = arr_block ? BLOCK_MASK : SECTOR_MASK;
    // a single locked block keeps the abort paths reachable
    assign target_locked = (addr & BLOCK_MASK) == lock_base;
    assign arr_rdata = mem[addr[16:0]];

    initial
    begin
        foreach (mem[i])
            mem[i] = 8'hFF;
    end

    always @(posedge mclk)
    begin
        // cells only lose ones when programmed
        if (arr_program)
            mem[arr_addr[16:0]] <= mem[arr_addr[16:0]] & arr_wdata;
        if (arr_erase)
            for (int i = 0; i < 131072; i++)
                if ((i[16:0] & emask[16:0]) == arr_addr[16:0])
                    mem[i] <= 8'hFF;
    end
endmodule

// ===== tb/flash_status_suspend_control_tb_top.sv
`timescale 1ns/1ps
module flash_status_suspend_control_tb_top;
    import flash_ctl_pkg::*;
    typedef struct {logic [7:0] exp; logic [7:0] mask;} note_t;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [7:0]  wdata = 8'h0;
    logic [31:0] lock_base = 32'h00FF0000;
    logic        target_locked;
    logic [7:0]  arr_rdata;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        arr_erase;
    logic        arr_program;
    logic        arr_block;
    logic [31:0] arr_addr;
    logic [7:0]  arr_wdata;
    logic [7:0]  lfsr_q = 8'h55;
    logic [7:0]  last_rd;
    logic [7:0]  dv [4];
    note_t       cur;
    note_t       notes [$];
    int          bad_count = 0;
    int          comparisons = 0;

    always #12.5 mclk = ~mclk;

    flash_status_ctl #(.SECTOR_ERASE_CNT(50), .BLOCK_ERASE_CNT(60)) flash_status_ctl_inst (
        .mclk(mclk), .rst(rst), .wr_stb(wr_stb), .rd_stb(rd_stb), .addr(addr),
        .wdata(wdata), .target_locked(target_locked), .arr_rdata(arr_rdata),
        .rd_data(rd_data), .rd_valid(rd_valid), .arr_erase(arr_erase),
        .arr_program(arr_program), .arr_block(arr_block), .arr_addr(arr_addr),
        .arr_wdata(arr_wdata));

    flash_array_model flash_array_model_inst (
        .mclk(mclk), .addr(addr), .lock_base(lock_base), .arr_erase(arr_erase),
        .arr_program(arr_program), .arr_block(arr_block), .arr_addr(arr_addr),
        .arr_wdata(arr_wdata), .target_locked(target_locked), .arr_rdata(arr_rdata));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] s,
                            input logic [7:0] m);
        comparisons++;
        if ((s & m) !== (e & m))
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask

    // answers are matched in order; a zero mask marks a poll read
    // sampled mid-cycle, where the registered answer has settled
    always @(negedge mclk)
        if (rd_valid === 1'b1)
        begin
            if (notes.size() == 0)
                cmp_byte("unrequested rd_valid", 8'h00, 8'h01, 8'hFF);
            else
            begin
                cur = notes.pop_front();
                if (cur.mask != 8'h00)
                    cmp_byte("rd_data", cur.exp, rd_data, cur.mask);
            end
        end

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 wr_stb = 1'b1;
        addr = a;
        wdata = d;
        @(posedge mclk);
        #1 wr_stb = 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge mclk);
        #1 rd_stb = 1'b1;
        addr = a;
        notes.push_back('{e, m});
        @(posedge mclk);
        #1 rd_stb = 1'b0;
        last_rd = rd_data;
        cmp_byte("rd_valid", 8'h01, {7'h0, rd_valid}, 8'h01);
    endtask

    task automatic chk(input logic [31:0] a, input logic [7:0] e);
        rd(a, e, 8'hFF);
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        wr(32'h0, CMD_READ_STATUS);
        rd(32'h0, 8'h00, 8'h00);
        while (last_rd[READY_BIT] !== 1'b1 && n < 2000)
        begin
            n++;
            rd(32'h0, 8'h00, 8'h00);
        end
        if (n >= 2000)
        begin
            bad_count++;
            $display("Error ready flag expected 1 seen %h", last_rd);
            summarize();
        end
    endtask

    initial
    begin
        for (int i = 0; i < 4; i++)
        begin
            lfsr_q = lfsr(lfsr_q);
            dv[i] = lfsr_q & 8'hFE;
        end
        repeat (6) @(posedge mclk);
        #1 rst = 1'b0;
        wr(32'h0, CMD_READ_STATUS);
        chk(32'h0, STATUS_RESET);
        chk(32'h1234, STATUS_RESET);
        $display("test reset status done");
        for (int k = 0; k < 2; k++)
        begin
            wr(32'h0, k ? CMD_PROGRAM_ALT : CMD_PROGRAM);
            wr(32'h100 + k, dv[k]);
            chk(32'h0, 8'h00);
            wait_ready();
            wr(32'h0, CMD_READ_ARRAY);
            chk(32'h100 + k, dv[k]);
        end
        $display("test program done");
        lock_base = 32'h0;
        wr(32'h0, CMD_PROGRAM);
        wr(32'h200, 8'h00);
        chk(32'h0, 8'h82);
        wr(32'h0, CMD_CLEAR_STATUS);
        wr(32'h0, CMD_READ_STATUS);
        chk(32'h0, STATUS_RESET);
        wr(32'h0, CMD_SECTOR_ERASE);
        wr(32'h155, CMD_RESUME);
        chk(32'h0, 8'h82);
        wr(32'h0, CMD_READ_ARRAY);
        chk(32'h200, 8'hFF);
        chk(32'h100, dv[0]);
        wr(32'h0, CMD_CLEAR_STATUS);
        lock_base = 32'h00FF0000;
        $display("test lock abort done");
        wr(32'h0, CMD_PROGRAM);
        wr(32'h1100, dv[2]);
        wait_ready();
        wr(32'h0, CMD_SECTOR_ERASE);
        wr(32'h155, CMD_RESUME);
        chk(32'h0, 8'h00);
        wait_ready();
        wr(32'h0, CMD_READ_ARRAY);
        chk(32'h101, 8'hFF);
        chk(32'h1100, dv[2]);
        wr(32'h0, CMD_BLOCK_ERASE);
        wr(32'h2345, CMD_RESUME);
        wait_ready();
        wr(32'h0, CMD_READ_ARRAY);
        chk(32'h1100, 8'hFF);
        $display("test erase done");
        wr(32'h0, CMD_SECTOR_ERASE);
        wr(32'h3000, CMD_RESUME);
        wr(32'h0, CMD_SUSPEND);
        chk(32'h0, 8'hC0);
        wr(32'h0, CMD_PROGRAM);
        wr(32'h4000, dv[1]);
        wait_ready();
        chk(32'h0, 8'hC0);
        wr(32'h0, CMD_PROGRAM);
        wr(32'h3020, 8'h00);
        chk(32'h0, 8'hC0);
        wr(32'h0, CMD_READ_ARRAY);
        chk(32'h4000, dv[1]);
        wr(32'h0, CMD_RESUME);
        chk(32'h0, 8'h00);
        wait_ready();
        wr(32'h0, CMD_READ_ARRAY);
        chk(32'h3020, 8'hFF);
        // resume lands while the suspend-time program still runs; no nesting
        wr(32'h0, CMD_SECTOR_ERASE);
        wr(32'h5000, CMD_RESUME);
        wr(32'h0, CMD_SUSPEND);
        wr(32'h0, CMD_PROGRAM);
        wr(32'h4001, dv[2]);
        wr(32'h0, CMD_RESUME);
        rd(32'h0, 8'h00, 8'hBF);
        wait_ready();
        chk(32'h0, STATUS_RESET);
        wr(32'h0, CMD_PROGRAM);
        wr(32'h4002, dv[3]);
        wr(32'h0, CMD_SUSPEND);
        chk(32'h0, 8'h00);
        wait_ready();
        chk(32'h0, STATUS_RESET);
        wr(32'h0, CMD_READ_ARRAY);
        chk(32'h4001, dv[2]);
        chk(32'h4002, dv[3]);
        $display("test suspend done");
        wr(32'h0, CMD_READ_ID);
        chk(MFR_ID_ADDR, MFR_CODE);
        chk(DEV_ID_ADDR, DEV_CODE);
        for (int i = 0; i < 8; i++)
            chk(SID_BASE + i, FACTORY_SID[8*i +: 8]);
        wr(32'h0, CMD_SID_PROGRAM);
        wr(SID_BASE + 8, 8'h5A);
        wr(32'h0, CMD_SID_PROGRAM);
        wr(SID_BASE, 8'h00);
        wr(32'h0, CMD_SID_LOCKOUT);
        wr(32'h0, SID_LOCKOUT_KEY);
        wr(32'h0, CMD_SID_PROGRAM);
        wr(SID_BASE + 9, 8'h00);
        wait_ready();
        wr(32'h0, CMD_READ_ID);
        chk(SID_BASE + 8, 8'h5A);
        chk(SID_BASE, FACTORY_SID[7:0]);
        chk(SID_BASE + 9, 8'hFF);
        wr(32'h0, CMD_READ_ARRAY);
        chk(32'h4000, dv[1]);
        $display("test identity done");
        repeat (4) @(posedge mclk);
        summarize();
    end
endmodule
